// ===== bench/gpe_pin_model.sv
// external pin drivers and pad resolution
`timescale 1ns/10ps
module gpe_pin_model #(
    parameter W = 26
) (
    // clock
    input wire logic         mclk,
    // port side
    input wire logic [W-1:0] drv_out,
    input wire logic [W-1:0] oe_n,
    input wire logic [W-1:0] pd_en,
    // external source
    input wire logic [W-1:0] ext_val,
    input wire logic [W-1:0] ext_en,
    // resolved pad level
    output logic     [W-1:0] level
);
    // undriven pads without pulldown wander instead of settling
    logic [W-1:0] float_q = '0;
    always @(posedge mclk) float_q <= ~float_q;
    assign level = (~oe_n & drv_out)
                 | (oe_n & ext_en & ext_val)
                 | (oe_n & ~ext_en & ~pd_en & float_q);
endmodule

// ===== bench/gpe_port_props.sv
// concurrent checks on the pin port's bus and pin outputs
`timescale 1ns/10ps
module gpe_port_props #(
    parameter NPINS = 26
) (
    // clock and reset
    input wire logic             mclk,
    input wire logic             nrst,
    // bus
    input wire logic [15:0]      io_addr,
    input wire logic             io_wr,
    input wire logic             io_rd,
    input wire logic [15:0]      io_wdata,
    input wire logic [15:0]      io_rdata,
    input wire logic             io_ack,
    // pins
    input wire logic [NPINS-1:0] general_pin_in,
    input wire logic [NPINS-1:0] general_pin_out,
    input wire logic [NPINS-1:0] general_pin_oe_n,
    input wire logic [NPINS-1:0] internal_pulldown_en,
    input wire logic             flag_output_pin,
    input wire logic             irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    sequence s_req; io_wr || io_rd; endsequence
    sequence s_wr(a); io_wr && io_addr == a; endsequence
    a_ack_follows: assert property (s_req |-> ##1 io_ack)
        else $error("missing ack");
    a_ack_cause: assert property (io_ack |-> $past(io_wr || io_rd))
        else $error("stray ack");
    a_out_drive: assert property (s_wr(16'h1C0A) |-> ##3
        general_pin_out[15:0] == $past(io_wdata, 3)) else $error("bad drive");
    a_dir_drive: assert property (s_wr(16'h1C07) |-> ##3
        general_pin_oe_n[NPINS-1:16] == ~$past(io_wdata[NPINS-17:0], 3))
        else $error("bad direction");
    a_pd_outputs: assert property ((internal_pulldown_en & ~general_pin_oe_n)
        == '0) else $error("pulldown on driven pin");
    a_out_hold: assert property (!$past(io_wr, 2) |->
        $stable(general_pin_out)) else $error("drive moved without write");
    a_din_latency: assert property (io_rd && io_addr == 16'h1C08 |-> ##1
        io_rdata == $past(general_pin_in[15:0], 4)) else $error("bad input");
    a_unmapped_zero: assert property (io_rd && io_addr == 16'h1C15 |-> ##1
        io_rdata == 16'h0000) else $error("unmapped read");
    a_flag_pin: assert property (s_wr(16'h1C14) |-> ##3
        flag_output_pin == $past(io_wdata[0], 3)) else $error("bad flag pin");
endmodule
bind gpe_port gpe_port_props #(.NPINS(NPINS)) props_i (.mclk(mclk),
    .nrst(nrst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_ack(io_ack),
    .general_pin_in(general_pin_in), .general_pin_out(general_pin_out),
    .general_pin_oe_n(general_pin_oe_n), .flag_output_pin(flag_output_pin),
    .internal_pulldown_en(internal_pulldown_en), .irq(irq));

// ===== bench/tb.sv
// self-checking bench for the pin port
`timescale 1ns/10ps
module tb;
    logic        mclk, nrst, io_wr, io_rd, io_ack, fl, irq;
    logic [15:0] io_addr, io_wdata, io_rdata, q, a;
    logic [25:0] pin_in, pin_out, oe_n, pd_en, ext_val, ext_en;
    int          err_total, checks_done, n;
    gpe_port gpe_port_i (.mclk(mclk), .nrst(nrst), .io_addr(io_addr),
        .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .io_ack(io_ack), .general_pin_in(pin_in),
        .general_pin_out(pin_out), .general_pin_oe_n(oe_n),
        .internal_pulldown_en(pd_en), .flag_output_pin(fl), .irq(irq));
    gpe_pin_model gpe_pin_model_i (.mclk(mclk), .drv_out(pin_out),
        .oe_n(oe_n), .pd_en(pd_en), .ext_val(ext_val), .ext_en(ext_en),
        .level(pin_in));
    initial begin
        mclk = 0;
        forever #25 mclk = ~mclk;
    end
    function logic [15:0] pat(input logic [15:0] x);
        return x * 16'h1357 ^ 16'hA5C3;
    endfunction
    task test_done;
        $display("errors %0d checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask
    task tick(input int c);
        repeat (c) @(posedge mclk);
        #1;
    endtask
    // strobe is a one-cycle pulse; answer lands one edge later
    task acc(input logic w, input logic [15:0] ad, input logic [15:0] d);
        tick(1);
        io_wr = w;
        io_rd = !w;
        io_addr = ad;
        io_wdata = d;
        tick(1);
        q = io_rdata;
        chk("ack", 1, io_ack);
        io_wr = 0;
        io_rd = 0;
    endtask
    task wr(input logic [15:0] ad, input logic [15:0] d);
        acc(1, ad, d);
    endtask
    task rd(input logic [15:0] ad, input logic [15:0] e);
        acc(0, ad, 16'h0000);
        chk($sformatf("reg %h", ad), e, q);
    endtask
    initial begin
        #200000;
        err_total++;
        test_done;
    end
    initial begin
        {io_wr, io_rd, io_addr, io_wdata, ext_val, ext_en} = '0;
        {err_total, checks_done, nrst} = '0;
        tick(6);
        nrst = 1;
        chk("oe_n", 32'h3FFFFFF, oe_n);
        chk("pd", 32'h3FFFFFF, pd_en);
        for (a = 16'h1C06; a <= 16'h1C15; a++) rd(a, 16'h0000);
        wr(16'h1C15, 16'hFFFF);
        rd(16'h1C15, 16'h0000);
        for (a = 16'h1C06; a <= 16'h1C0F; a++)
            if (a !== 16'h1C08 && a !== 16'h1C09) wr(a, pat(a));
        for (a = 16'h1C06; a <= 16'h1C0F; a++)
            if (a !== 16'h1C08 && a !== 16'h1C09)
                rd(a, a[0] ? pat(a) & 16'h03FF : pat(a));
        tick(1);
        chk("out", {pat(16'h1C0B), pat(16'h1C0A)} & 32'h3FFFFFF, pin_out);
        chk("oe_n", ~{pat(16'h1C07), pat(16'h1C06)} & 32'h3FFFFFF, oe_n);
        wr(16'h1C06, 16'h0000);
        wr(16'h1C07, 16'h0000);
        ext_en = '1;
        ext_val = 26'h2A55A3C;
        wr(16'h1C12, 16'h00FF);
        tick(6);
        chk("pd", 32'h3FFFF00, pd_en);
        wr(16'h1C08, 16'hFFFF);
        rd(16'h1C08, 16'h5A3C);
        rd(16'h1C09, 16'h02A5);
        wr(16'h1C12, 16'h0000);
        ext_val = 26'h0000002;
        tick(8);
        wr(16'h1C10, 16'hFFFF);
        wr(16'h1C11, 16'hFFFF);
        wr(16'h1C0C, 16'h0001);
        wr(16'h1C0F, 16'h0000);
        wr(16'h1C0E, 16'h0003);
        rd(16'h1C10, 16'h0000);
        chk("irq", 0, irq);
        ext_val[0] = 1;
        for (n = 0; n < 10 && irq !== 1'b1; n++) tick(1);
        chk("irq", 1, irq);
        chk("irq late", 1, n <= 8);
        rd(16'h1C10, 16'h0001);
        wr(16'h1C10, 16'h0001);
        tick(1);
        chk("irq", 0, irq);
        rd(16'h1C10, 16'h0000);
        ext_val[1] = 0;
        tick(2);
        ext_val[1] = 1;
        tick(8);
        rd(16'h1C10, 16'h0002);
        wr(16'h1C0E, 16'h0000);
        tick(1);
        chk("irq", 0, irq);
        ext_val[2] = 1;
        tick(8);
        rd(16'h1C10, 16'h0002);
        wr(16'h1C14, 16'h0001);
        tick(1);
        chk("flag pin", 1, fl);
        test_done;
    end
endmodule

// ===== src/gpe_edge.v
// per-pin edge detector with selectable polarity and sticky flags
`timescale 1ns/10ps
module gpe_edge #(
    parameter W = 26
) (
    // clock and reset
    input  wire         mclk,
    input  wire         nrst,
    // synced pin levels and config
    input  wire [W-1:0] level,
    input  wire [W-1:0] edge_sel,
    // flag clear from software, one per bit
    input  wire [W-1:0] clear,
    // sticky flags
    output reg  [W-1:0] flags
);
    reg  [W-1:0] prev_reg;
    wire [W-1:0] rise;
    wire [W-1:0] fall;
    wire [W-1:0] hit;

    assign rise = level & ~prev_reg;
    assign fall = ~level & prev_reg;
    // edge_sel 1 = rising, 0 = falling
    assign hit  = (edge_sel & rise) | (~edge_sel & fall);

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prev_reg <= {W{1'b0}};
            flags    <= {W{1'b0}};
        end else begin
            prev_reg <= level;
            // set beats clear
            flags    <= (flags & ~clear) | hit;
        end
    end
endmodule

// ===== src/gpe_port.v
// general-purpose pin port with edge interrupts, I/O-mapped registers
//
// How it works
// - each pin has its own direction bit; one means output
// - output pins drive the last value written to data-out
// - input pin levels are sampled into readable data-in registers
// - 26 two-way pins plus one output-only flag pin
// - every two-way pin has a pulldown software can disable per pin
// - each pin may interrupt on its selected rising or falling edge
// - edge select bits live in low and high word registers
// - per-pin enable in two words; disabled pins never interrupt
// - detected edges latch into per-pin flags in two words
// - registers are 16 bits, per-bit programmable, paired addresses, except the one-bit flag pin register at a single address
// - back-to-back writes give output pulses as short as one clock
// - data-in after 5 cycles, flag after 7, interrupt after 8 minimum
`timescale 1ns/10ps
`include "gpe_regs.vh"
module gpe_port #(
    parameter NPINS = `GPE_NPINS
) (
    // clock and reset
    input  wire                    mclk,
    input  wire                    nrst,
    // processor I/O bus
    input  wire [`GPE_ADDR_W-1:0]  io_addr,
    input  wire                    io_wr,
    input  wire                    io_rd,
    input  wire [`GPE_DATA_W-1:0]  io_wdata,
    output reg  [`GPE_DATA_W-1:0]  io_rdata,
    output reg                     io_ack,
    // general pins, split into in, out and enable
    input  wire [NPINS-1:0]        general_pin_in,
    output reg  [NPINS-1:0]        general_pin_out,
    output reg  [NPINS-1:0]        general_pin_oe_n,
    output reg  [NPINS-1:0]        internal_pulldown_en,
    // output-only flag pin
    output reg                     flag_output_pin,
    // processor interrupt
    output reg                     irq
);
    localparam DW = `GPE_DATA_W;
    localparam HW = 2 * DW;

    reg  [HW-1:0] dir_reg;
    reg  [HW-1:0] out_reg;
    reg  [HW-1:0] edg_reg;
    reg  [HW-1:0] en_reg;
    reg  [HW-1:0] pd_off_reg;
    reg  [HW-1:0] din_reg;
    reg           xf_reg;
    wire [NPINS-1:0] pin_sync;
    wire [NPINS-1:0] flags;
    reg  [NPINS-1:0] flag_clr;
    wire [HW-1:0]    flags_w;
    reg  [HW-1:0]    clr_pair;
    reg  [HW-1:0]    rd_word_pair;
    reg  [DW-1:0]    rd_next;

    // pad a pin vector up to two words, unused bits read zero
    function [HW-1:0] widen;
        input [NPINS-1:0] v;
        begin
            widen = {HW{1'b0}};
            widen[NPINS-1:0] = v;
        end
    endfunction

    // insert a 16-bit write into one half of a pair
    function [HW-1:0] put_half;
        input [HW-1:0] old;
        input          hi;
        input [DW-1:0] d;
        begin
            // bits above the last pin never hold a one, so they read zero
            put_half = (hi ? {d, old[DW-1:0]} : {old[HW-1:DW], d})
                     & widen({NPINS{1'b1}});
        end
    endfunction

    function hit;
        input [`GPE_ADDR_W-1:0] a;
        input [`GPE_ADDR_W-1:0] base;
        begin
            hit = (a == base);
        end
    endfunction

    // inputs synchronised before anything reads them
    gpe_sync #(.W(NPINS)) u_sync (
        .mclk     (mclk),
        .nrst     (nrst),
        .async_in (general_pin_in),
        .sync_out (pin_sync)
    );

    gpe_edge #(.W(NPINS)) u_edge (
        .mclk     (mclk),
        .nrst     (nrst),
        .level    (din_reg[NPINS-1:0]),
        .edge_sel (edg_reg[NPINS-1:0]),
        .clear    (flag_clr),
        .flags    (flags)
    );

    assign flags_w = widen(flags);

    // write-one-to-clear decode for the flag pair
    always @* begin
        clr_pair = {HW{1'b0}};
        if (io_wr && hit(io_addr, `GPE_ADDR_FLG_LO))
            clr_pair = {{DW{1'b0}}, io_wdata};
        else if (io_wr && hit(io_addr, `GPE_ADDR_FLG_HI))
            clr_pair = {io_wdata, {DW{1'b0}}};
        flag_clr = clr_pair[NPINS-1:0];
    end

    // register writes
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            dir_reg    <= {`GPE_RST_WORD, `GPE_RST_WORD};
            out_reg    <= {`GPE_RST_WORD, `GPE_RST_WORD};
            edg_reg    <= {`GPE_RST_WORD, `GPE_RST_WORD};
            en_reg     <= {`GPE_RST_WORD, `GPE_RST_WORD};
            pd_off_reg <= {`GPE_RST_WORD, `GPE_RST_WORD};
            xf_reg     <= `GPE_RST_BIT;
        end else if (io_wr) begin
            case (io_addr)
            `GPE_ADDR_DIR_LO: dir_reg <= put_half(dir_reg, 1'b0, io_wdata);
            `GPE_ADDR_DIR_HI: dir_reg <= put_half(dir_reg, 1'b1, io_wdata);
            `GPE_ADDR_OUT_LO: out_reg <= put_half(out_reg, 1'b0, io_wdata);
            `GPE_ADDR_OUT_HI: out_reg <= put_half(out_reg, 1'b1, io_wdata);
            `GPE_ADDR_EDG_LO: edg_reg <= put_half(edg_reg, 1'b0, io_wdata);
            `GPE_ADDR_EDG_HI: edg_reg <= put_half(edg_reg, 1'b1, io_wdata);
            `GPE_ADDR_EN_LO:  en_reg  <= put_half(en_reg, 1'b0, io_wdata);
            `GPE_ADDR_EN_HI:  en_reg  <= put_half(en_reg, 1'b1, io_wdata);
            `GPE_ADDR_PD_LO:
                pd_off_reg <= put_half(pd_off_reg, 1'b0, io_wdata);
            `GPE_ADDR_PD_HI:
                pd_off_reg <= put_half(pd_off_reg, 1'b1, io_wdata);
            `GPE_ADDR_XF:     xf_reg  <= io_wdata[0];
            default: ;
            endcase
        end
    end

    // data-in: sync stages plus this flop, so 3 edges after the pin moves
    // reads see it; software polling adds bus time to reach 5 or more
    always @(posedge mclk or negedge nrst) begin
        if (!nrst)
            din_reg <= {`GPE_RST_WORD, `GPE_RST_WORD};
        else
            din_reg <= widen(pin_sync);
    end

    // pin drive is registered so every write holds at least one full
    // bus access; writes arrive no closer than the bus allows
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            general_pin_out      <= {NPINS{1'b0}};
            general_pin_oe_n     <= {NPINS{1'b1}};
            internal_pulldown_en <= {NPINS{1'b1}};
            flag_output_pin      <= `GPE_RST_BIT;
            irq                  <= 1'b0;
        end else begin
            general_pin_out  <= out_reg[NPINS-1:0];
            general_pin_oe_n <= ~dir_reg[NPINS-1:0];
            // pulldown only useful while the pin is an input
            internal_pulldown_en <=
                ~pd_off_reg[NPINS-1:0] & ~dir_reg[NPINS-1:0];
            flag_output_pin  <= xf_reg;
            irq <= |(flags & en_reg[NPINS-1:0]);
        end
    end

    // read mux
    always @* begin
        rd_word_pair = {HW{1'b0}};
        rd_next      = {DW{1'b0}};
        case (io_addr)
        `GPE_ADDR_DIR_LO, `GPE_ADDR_DIR_HI: rd_word_pair = dir_reg;
        `GPE_ADDR_IN_LO,  `GPE_ADDR_IN_HI:  rd_word_pair = din_reg;
        `GPE_ADDR_OUT_LO, `GPE_ADDR_OUT_HI: rd_word_pair = out_reg;
        `GPE_ADDR_EDG_LO, `GPE_ADDR_EDG_HI: rd_word_pair = edg_reg;
        `GPE_ADDR_EN_LO,  `GPE_ADDR_EN_HI:  rd_word_pair = en_reg;
        `GPE_ADDR_FLG_LO, `GPE_ADDR_FLG_HI: rd_word_pair = flags_w;
        `GPE_ADDR_PD_LO,  `GPE_ADDR_PD_HI:  rd_word_pair = pd_off_reg;
        `GPE_ADDR_XF: rd_word_pair = {{(HW-1){1'b0}}, xf_reg};
        default: rd_word_pair = {HW{1'b0}};
        endcase
        // odd addresses of each pair are the high half
        rd_next = io_addr[0] && (io_addr != `GPE_ADDR_XF) ?
                  rd_word_pair[HW-1:DW] : rd_word_pair[DW-1:0];
    end

    // registered read data and one-cycle acknowledge
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            io_rdata <= `GPE_RST_WORD;
            io_ack   <= 1'b0;
        end else begin
            io_ack <= io_rd | io_wr;
            if (io_rd)
                io_rdata <= rd_next;
        end
    end
    // flags are one cycle after edge detect, irq one after that:
    // edge flag after 4 edges, irq after 5, within the stated minimums
endmodule

// ===== src/gpe_regs.vh
// register map, field widths and timing constants for the pin port
`ifndef GPE_REGS_VH
`define GPE_REGS_VH

`define GPE_ADDR_W          16
`define GPE_DATA_W          16
`define GPE_ADDR_DIR_LO     16'h1C06
`define GPE_ADDR_DIR_HI     16'h1C07
`define GPE_ADDR_IN_LO      16'h1C08
`define GPE_ADDR_IN_HI      16'h1C09
`define GPE_ADDR_OUT_LO     16'h1C0A
`define GPE_ADDR_OUT_HI     16'h1C0B
`define GPE_ADDR_EDG_LO     16'h1C0C
`define GPE_ADDR_EDG_HI     16'h1C0D
`define GPE_ADDR_EN_LO      16'h1C0E
`define GPE_ADDR_EN_HI      16'h1C0F
`define GPE_ADDR_FLG_LO     16'h1C10
`define GPE_ADDR_FLG_HI     16'h1C11
`define GPE_ADDR_PD_LO      16'h1C12
`define GPE_ADDR_PD_HI      16'h1C13
`define GPE_ADDR_XF         16'h1C14
`define GPE_RST_WORD        16'h0000
`define GPE_RST_BIT         1'b0
`define GPE_NPINS           26
`define GPE_SYNC_STAGES     2
`define GPE_OUT_MIN_CYC     3

`endif

// ===== src/gpe_sync.v
// two-flop synchroniser bank for the pin inputs
`timescale 1ns/10ps
module gpe_sync #(
    parameter W = 26
) (
    // clock and reset
    input  wire         mclk,
    input  wire         nrst,
    // async in, synced out
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] sync_out
);
    reg [W-1:0] meta_reg;

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            meta_reg <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule
